// >>> design/byte_op_cfg.svh
// constants for the byte operation and indirect load datapath
`ifndef BYTE_OP_CFG_SVH
`define BYTE_OP_CFG_SVH

// ==================================================
// register map (byte addresses on the apb bus)
`define ADDR_W 12
`define REG_CMD 12'h000
`define REG_WREG 12'h004
`define REG_STATUS 12'h008
`define REG_PTR0 12'h00c
`define REG_PTR1 12'h010
// file register window: paddr[11:9] == 3'h1, word index in paddr[8:2]
`define WIN_HI 11
`define WIN_LO 9
`define WIN_SEL 3'h1

// ==================================================
// field positions and widths
`define CMD_W 21
`define STAT_CARRY 0
`define STAT_ZERO 1
`define STAT_BUSY 2
`define STAT_BAD 3
`define PTR_W 16
`define OFS_W 6

// ==================================================
// reset values and steps
`define WREG_RST 8'h00
`define PTR_RST 16'h0000
`define PTR_STEP 16'h0001
`define BYTE_ONE 8'h01
`define BYTE_ZERO 8'h00

`endif

// >>> design/byte_op_pkg.sv
// types shared by the byte operation datapath
`default_nettype none
package byte_op_pkg;

   // ==================================================
   // states, opcodes, pointer update codes
   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_fetch = 3'b010,
      st_exec = 3'b100
   } state_e;

   typedef enum logic [2:0] {
      increment_op = 3'h0,
      inclusive_or_op = 3'h1,
      shift_left_op = 3'h2,
      shift_right_op = 3'h3,
      move_file_op = 3'h4,
      indirect_load_op = 3'h5
   } opcode_e;

   typedef enum logic [1:0] {
      pm_pre_inc = 2'h0,
      pm_pre_dec = 2'h1,
      pm_post_inc = 2'h2,
      pm_post_dec = 2'h3
   } pointer_update_code_e;

   // ==================================================
   // command word as written to the command register
   typedef struct packed {
      logic [5:0] offset;
      logic rel;
      logic [1:0] mode;
      logic sel;
      logic [6:0] faddr;
      logic dest;
      logic [2:0] op;
   } cmd_s;

endpackage
`default_nettype wire

// >>> design/file_mem.sv
// single port file register memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module file_mem #(
   parameter int DW = 8,
   parameter int DEPTH = 128,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
);

   logic [DW-1:0] mem [DEPTH];

   // ==================================================
   // storage has no reset; software loads it over the bus
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdata <= '0;
      end else begin
         rdata <= mem[addr];
      end
   end

endmodule
`default_nettype wire

// >>> design/byte_op_datapath.sv
// byte operation and indirect load datapath with apb register access
// Notes on behaviour
// RL1 - increment adds one to the file register and updates only zero.
// RL2 - destination 0 writes the working register, 1 the file register, except indirect load, which always writes wreg.
// RL3 - inclusive or of working and file register updates only zero.
// RL4 - left shift sends bit 7 to carry, zero into bit 0, updates c and z.
// RL5 - right shift sends bit 0 to carry, zero into bit 7, updates c and z.
// RL6 - move file copies the register to the destination and updates zero.
// RL7 - indirect load copies the pointed byte into wreg and updates zero.
// RL8 - update code 00 pre inc, 01 pre dec, 10 post inc, 11 post dec.
// RL9 - pre modes access and keep pointer +/- 1; post modes step after.
// RL10 - relative form adds a signed offset -32..31 and keeps the pointer.
// RL11 - pointers are 16 bits wide and wrap modulo 65536 when stepped.
// RL12 - stepping a pointer changes no flag; only loaded data sets zero.
// RL13 - zero, when updated, is set for a zero 8 bit result, else cleared.
`timescale 1ns/1ps
`default_nettype none
`include "byte_op_cfg.svh"

module byte_op_datapath #(
   parameter int DEPTH = 128
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   localparam int AW = $clog2(DEPTH);

   byte_op_pkg::state_e state, next_state;
   byte_op_pkg::cmd_s cmd, next_cmd;
   logic [7:0] wreg, next_wreg;
   logic carry, next_carry;
   logic zero, next_zero;
   logic bad_op, next_bad_op;
   logic [1:0][`PTR_W-1:0] ptr, next_ptr;
   logic [AW-1:0] ea, next_ea;
   logic mem_wait, next_mem_wait;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic mem_we;
   logic [AW-1:0] mem_addr;
   logic [7:0] mem_wdata, mem_rdata;
   logic [7:0] result;
   logic res_carry;
   logic [`PTR_W-1:0] sel_ptr, off_ext, eff_full, ptr_after;
   logic apb_acc, in_window, op_legal;

   // ==================================================
   // file register storage
   file_mem #(
      .DW(8),
      .DEPTH(DEPTH),
      .AW(AW)
   ) i_file_mem (
      .clk(clk),
      .srst(srst),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   // ==================================================
   // result of the current operation
   always_comb begin
      result = mem_rdata;
      res_carry = carry;
      case (cmd.op)
         byte_op_pkg::increment_op: begin
            result = mem_rdata + `BYTE_ONE; // RL1
         end
         byte_op_pkg::inclusive_or_op: begin
            result = wreg | mem_rdata; // RL3
         end
         byte_op_pkg::shift_left_op: begin
            result = {mem_rdata[6:0], 1'b0}; // RL4
            res_carry = mem_rdata[7]; // RL4
         end
         byte_op_pkg::shift_right_op: begin
            result = {1'b0, mem_rdata[7:1]}; // RL5
            res_carry = mem_rdata[0]; // RL5
         end
         default: begin
            result = mem_rdata; // RL6 RL7
         end
      endcase
   end

   // ==================================================
   // effective address and pointer step
   always_comb begin
      sel_ptr = ptr[cmd.sel];
      off_ext = {{(`PTR_W-`OFS_W){cmd.offset[5]}}, cmd.offset};
      eff_full = sel_ptr;
      ptr_after = sel_ptr;
      if (cmd.rel) begin
         eff_full = sel_ptr + off_ext; // RL10
      end else begin
         unique case (byte_op_pkg::pointer_update_code_e'(cmd.mode))
            byte_op_pkg::pm_pre_inc: begin
               eff_full = sel_ptr + `PTR_STEP; // RL8 RL9 RL11
               ptr_after = sel_ptr + `PTR_STEP;
            end
            byte_op_pkg::pm_pre_dec: begin
               eff_full = sel_ptr - `PTR_STEP; // RL8 RL9 RL11
               ptr_after = sel_ptr - `PTR_STEP;
            end
            byte_op_pkg::pm_post_inc: begin
               ptr_after = sel_ptr + `PTR_STEP; // RL8 RL9 RL11
            end
            byte_op_pkg::pm_post_dec: begin
               ptr_after = sel_ptr - `PTR_STEP; // RL8 RL9 RL11
            end
         endcase
      end
   end

   // ==================================================
   // control, bus answer and execution
   assign apb_acc = psel & penable & ~pready;
   assign in_window = paddr[`WIN_HI:`WIN_LO] == `WIN_SEL;
   assign op_legal = pwdata[2:0] <= 3'(byte_op_pkg::indirect_load_op);

   always_comb begin
      next_state = state;
      next_cmd = cmd;
      next_wreg = wreg;
      next_carry = carry;
      next_zero = zero;
      next_bad_op = bad_op;
      next_ptr = ptr;
      next_ea = ea;
      next_mem_wait = mem_wait;
      next_prdata = prdata;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      mem_we = 1'b0;
      mem_addr = ea;
      mem_wdata = result;
      unique case (state)
         byte_op_pkg::st_idle: begin
            // bus waits while a command runs, so the memory port is never shared
            if (apb_acc && in_window) begin
               mem_addr = paddr[AW+1:2];
               mem_wdata = pwdata[7:0];
               if (pwrite) begin
                  mem_we = 1'b1;
                  next_pready = 1'b1;
               end else if (!mem_wait) begin
                  next_mem_wait = 1'b1;
               end else begin
                  next_mem_wait = 1'b0;
                  next_pready = 1'b1;
                  next_prdata = {24'h0, mem_rdata};
               end
            end else if (apb_acc) begin
               next_pready = 1'b1;
               next_prdata = '0;
               case (paddr)
                  `REG_CMD: begin
                     next_prdata = {11'h0, cmd};
                     if (pwrite && op_legal) begin
                        next_cmd = byte_op_pkg::cmd_s'(pwdata[`CMD_W-1:0]);
                        next_bad_op = 1'b0;
                        next_state = byte_op_pkg::st_fetch;
                     end else if (pwrite) begin
                        next_bad_op = 1'b1;
                     end
                  end
                  `REG_WREG: begin
                     next_prdata = {24'h0, wreg};
                     if (pwrite) begin
                        next_wreg = pwdata[7:0];
                     end
                  end
                  `REG_STATUS: begin
                     next_prdata[`STAT_CARRY] = carry;
                     next_prdata[`STAT_ZERO] = zero;
                     next_prdata[`STAT_BAD] = bad_op;
                     if (pwrite) begin
                        next_carry = pwdata[`STAT_CARRY];
                        next_zero = pwdata[`STAT_ZERO];
                     end
                  end
                  `REG_PTR0: begin
                     next_prdata = {16'h0, ptr[0]};
                     if (pwrite) begin
                        next_ptr[0] = pwdata[`PTR_W-1:0];
                     end
                  end
                  `REG_PTR1: begin
                     next_prdata = {16'h0, ptr[1]};
                     if (pwrite) begin
                        next_ptr[1] = pwdata[`PTR_W-1:0];
                     end
                  end
                  default: begin
                     next_pslverr = 1'b1;
                  end
               endcase
            end
         end
         byte_op_pkg::st_fetch: begin
            if (cmd.op == byte_op_pkg::indirect_load_op) begin
               // only the memory window of the pointer is modelled
               mem_addr = eff_full[AW-1:0]; // RL7
               next_ptr[cmd.sel] = ptr_after; // RL9 RL12
            end else begin
               mem_addr = AW'(cmd.faddr);
            end
            next_ea = mem_addr;
            next_state = byte_op_pkg::st_exec;
         end
         byte_op_pkg::st_exec: begin
            next_zero = result == `BYTE_ZERO; // RL13
            if (cmd.op == byte_op_pkg::shift_left_op ||
                cmd.op == byte_op_pkg::shift_right_op) begin
               next_carry = res_carry; // RL4 RL5
            end
            if (cmd.dest && cmd.op != byte_op_pkg::indirect_load_op) begin
               mem_we = 1'b1; // RL2
            end else begin
               next_wreg = result; // RL2 RL7
            end
            next_state = byte_op_pkg::st_idle;
         end
      endcase
      if (state != byte_op_pkg::st_idle) begin
         next_prdata[`STAT_BUSY] = next_prdata[`STAT_BUSY];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= byte_op_pkg::st_idle;
         cmd <= '0;
         wreg <= `WREG_RST;
         carry <= 1'b0;
         zero <= 1'b0;
         bad_op <= 1'b0;
         ptr <= {2{`PTR_RST}};
         ea <= '0;
         mem_wait <= 1'b0;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         state <= next_state;
         cmd <= next_cmd;
         wreg <= next_wreg;
         carry <= next_carry;
         zero <= next_zero;
         bad_op <= next_bad_op;
         ptr <= next_ptr;
         ea <= next_ea;
         mem_wait <= next_mem_wait;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ==================================================
   // checks
   a_inc_result: assert property ( // RL1
      @(posedge clk) disable iff (srst)
      state == byte_op_pkg::st_exec && !cmd.dest &&
      cmd.op == byte_op_pkg::increment_op
      |=> wreg == 8'($past(mem_rdata) + `BYTE_ONE))
      else $error("increment result wrong");

   a_dest_file: assert property ( // RL2
      @(posedge clk) disable iff (srst)
      state == byte_op_pkg::st_exec && cmd.dest &&
      cmd.op != byte_op_pkg::indirect_load_op
      |-> mem_we && mem_wdata == result ##1 $stable(wreg))
      else $error("file destination not written");

   a_ior_result: assert property ( // RL3
      @(posedge clk) disable iff (srst)
      state == byte_op_pkg::st_exec && !cmd.dest &&
      cmd.op == byte_op_pkg::inclusive_or_op
      |=> wreg == ($past(wreg) | $past(mem_rdata)) && $stable(carry))
      else $error("inclusive or wrong");

   a_shl_carry: assert property ( // RL4
      @(posedge clk) disable iff (srst)
      state == byte_op_pkg::st_exec &&
      cmd.op == byte_op_pkg::shift_left_op
      |=> carry == $past(mem_rdata[7]) && !$past(result[0]))
      else $error("left shift carry wrong");

   a_shr_carry: assert property ( // RL5
      @(posedge clk) disable iff (srst)
      state == byte_op_pkg::st_exec &&
      cmd.op == byte_op_pkg::shift_right_op
      |=> carry == $past(mem_rdata[0]) && !$past(result[7]))
      else $error("right shift carry wrong");

   a_cmd_two_steps: assert property ( // RL6
      @(posedge clk) disable iff (srst)
      state == byte_op_pkg::st_fetch
      |=> state == byte_op_pkg::st_exec ##1 state == byte_op_pkg::st_idle)
      else $error("command took wrong number of cycles");

   a_ind_to_w: assert property ( // RL7
      @(posedge clk) disable iff (srst)
      state == byte_op_pkg::st_exec &&
      cmd.op == byte_op_pkg::indirect_load_op
      |-> !mem_we ##1 wreg == $past(mem_rdata))
      else $error("indirect load did not reach working register");

   a_pre_inc: assert property ( // RL9
      @(posedge clk) disable iff (srst)
      state == byte_op_pkg::st_fetch && !cmd.rel &&
      cmd.op == byte_op_pkg::indirect_load_op &&
      cmd.mode == byte_op_pkg::pm_pre_inc
      |-> mem_addr == AW'(sel_ptr + `PTR_STEP)
      ##1 sel_ptr == 16'($past(sel_ptr) + `PTR_STEP))
      else $error("pre increment address or pointer wrong");

   a_post_dec: assert property ( // RL8
      @(posedge clk) disable iff (srst)
      state == byte_op_pkg::st_fetch && !cmd.rel &&
      cmd.op == byte_op_pkg::indirect_load_op &&
      cmd.mode == byte_op_pkg::pm_post_dec
      |-> mem_addr == AW'(sel_ptr)
      ##1 sel_ptr == 16'($past(sel_ptr) - `PTR_STEP))
      else $error("post decrement address or pointer wrong");

   a_rel_keep: assert property ( // RL10
      @(posedge clk) disable iff (srst)
      state == byte_op_pkg::st_fetch && cmd.rel &&
      cmd.op == byte_op_pkg::indirect_load_op
      |-> mem_addr == AW'(sel_ptr + off_ext) ##1 $stable(ptr))
      else $error("relative access moved pointer");

   a_ptr_wrap: assert property ( // RL11
      @(posedge clk) disable iff (srst)
      state == byte_op_pkg::st_fetch && !cmd.rel &&
      cmd.op == byte_op_pkg::indirect_load_op && !cmd.mode[0] &&
      sel_ptr == 16'hffff
      |=> sel_ptr == 16'h0000)
      else $error("pointer did not wrap");

   a_ptr_no_flag: assert property ( // RL12
      @(posedge clk) disable iff (srst)
      state == byte_op_pkg::st_fetch
      |=> $stable(carry) && $stable(zero))
      else $error("pointer step touched flags");

   a_zero_def: assert property ( // RL13
      @(posedge clk) disable iff (srst)
      state == byte_op_pkg::st_exec
      |=> zero == ($past(result) == `BYTE_ZERO))
      else $error("zero flag wrong");

endmodule
`default_nettype wire

// >>> dv/byte_op_datapath_tb.sv
// self-checking testbench for the byte operation datapath
`timescale 1ns/1ps
`default_nettype none
`include "byte_op_cfg.svh"

module byte_op_datapath_tb;
   // ==================================================
   // clock, reset, apb signals
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [`ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   int errors = 0;
   int comparisons = 0;

   always #5 clk = ~clk;

   byte_op_datapath #(.DEPTH(128)) i_byte_op_datapath (
      .clk(clk),
      .srst(srst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr)
   );

   // ==================================================
   // bus and compare tasks
   task automatic end_of_test();
      if (errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // pready is read right after each rising edge, i.e. the value sampled
   // at that edge; read data and error are taken at that same edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
   endtask

   function automatic logic [11:0] win(input logic [6:0] i);
      return {`WIN_SEL, i, 2'b00};
   endfunction

   function automatic logic [31:0] mk_cmd(input logic [2:0] op,
      input logic dest, input logic [6:0] fa, input logic sel,
      input logic [1:0] mode, input logic rel, input logic [5:0] ofs);
      byte_op_pkg::cmd_s c;
      c.op = op;
      c.dest = dest;
      c.faddr = fa;
      c.sel = sel;
      c.mode = mode;
      c.rel = rel;
      c.offset = ofs;
      return {11'h000, c};
   endfunction

   // ==================================================
   // scenario helpers: status words are {zero, carry}
   task automatic byte_case(input logic [2:0] op, input logic dest,
      input logic [6:0] fa, input logic [7:0] f, input logic [7:0] w,
      input logic [1:0] st_in, input logic [7:0] res,
      input logic [1:0] st_out);
      wr(win(fa), {24'h0, f});
      wr(`REG_WREG, {24'h0, w});
      wr(`REG_STATUS, {30'h0, st_in});
      wr(`REG_CMD, mk_cmd(op, dest, fa, 1'b0, 2'b00, 1'b0, 6'h00));
      rd_chk(dest ? win(fa) : `REG_WREG, {24'h0, res});
      rd_chk(dest ? `REG_WREG : win(fa), {24'h0, dest ? w : f});
      rd_chk(`REG_STATUS, {30'h0, st_out});
   endtask

   // a decoy byte sits at the pointer's own slot to expose a wrong address
   task automatic ind_case(input logic sel, input logic [1:0] mode,
      input logic rel, input logic [5:0] ofs, input logic [15:0] ptr,
      input logic [15:0] ea, input logic [15:0] nptr,
      input logic [7:0] data, input logic cin);
      logic [11:0] pa;
      logic [11:0] po;
      pa = sel ? `REG_PTR1 : `REG_PTR0;
      po = sel ? `REG_PTR0 : `REG_PTR1;
      wr(win(ptr[6:0]), 32'hee);
      wr(win(ea[6:0]), {24'h0, data});
      wr(pa, {16'h0, ptr});
      wr(po, 32'h1234);
      wr(`REG_WREG, 32'h99);
      wr(`REG_STATUS, {30'h0, 1'b1, cin});
      wr(`REG_CMD, mk_cmd(byte_op_pkg::indirect_load_op, 1'b1, 7'h00,
                          sel, mode, rel, ofs));
      rd_chk(`REG_WREG, {24'h0, data});
      rd_chk(pa, {16'h0, nptr});
      rd_chk(po, 32'h1234);
      rd_chk(`REG_STATUS, {30'h0, data == 8'h00, cin});
   endtask

   // ==================================================
   // scenarios
   task automatic test_reset();
      rd_chk(`REG_WREG, 32'h0);
      rd_chk(`REG_STATUS, 32'h0);
      rd_chk(`REG_PTR0, 32'h0);
      rd_chk(`REG_PTR1, 32'h0);
   endtask

   task automatic test_increment();
      byte_case(byte_op_pkg::increment_op, 1'b0, 7'h05, 8'hff, 8'h33,
                2'b01, 8'h00, 2'b11);
      byte_case(byte_op_pkg::increment_op, 1'b1, 7'h7f, 8'h41, 8'h00,
                2'b10, 8'h42, 2'b00);
   endtask

   task automatic test_ior();
      byte_case(byte_op_pkg::inclusive_or_op, 1'b1, 7'h10, 8'hf0, 8'h0f,
                2'b01, 8'hff, 2'b01);
      byte_case(byte_op_pkg::inclusive_or_op, 1'b0, 7'h00, 8'h00, 8'h00,
                2'b00, 8'h00, 2'b10);
   endtask

   task automatic test_shifts();
      byte_case(byte_op_pkg::shift_left_op, 1'b0, 7'h20, 8'h81, 8'h11,
                2'b00, 8'h02, 2'b01);
      byte_case(byte_op_pkg::shift_left_op, 1'b1, 7'h21, 8'h80, 8'h11,
                2'b00, 8'h00, 2'b11);
      byte_case(byte_op_pkg::shift_left_op, 1'b0, 7'h22, 8'h40, 8'h11,
                2'b01, 8'h80, 2'b00);
      byte_case(byte_op_pkg::shift_right_op, 1'b1, 7'h23, 8'h01, 8'h11,
                2'b00, 8'h00, 2'b11);
      byte_case(byte_op_pkg::shift_right_op, 1'b0, 7'h24, 8'hfe, 8'h11,
                2'b01, 8'h7f, 2'b00);
      byte_case(byte_op_pkg::shift_right_op, 1'b1, 7'h25, 8'h81, 8'h11,
                2'b10, 8'h40, 2'b01);
   endtask

   task automatic test_move();
      byte_case(byte_op_pkg::move_file_op, 1'b1, 7'h30, 8'h00, 8'h55,
                2'b01, 8'h00, 2'b11);
      byte_case(byte_op_pkg::move_file_op, 1'b0, 7'h31, 8'h9c, 8'h55,
                2'b10, 8'h9c, 2'b00);
   endtask

   task automatic test_indirect();
      ind_case(1'b0, 2'b00, 1'b0, 6'h00, 16'h0010, 16'h0011, 16'h0011,
               8'h5a, 1'b1);
      ind_case(1'b1, 2'b01, 1'b0, 6'h00, 16'h0010, 16'h000f, 16'h000f,
               8'h00, 1'b0);
      ind_case(1'b0, 2'b10, 1'b0, 6'h00, 16'hffff, 16'hffff, 16'h0000,
               8'ha5, 1'b1);
      ind_case(1'b1, 2'b11, 1'b0, 6'h00, 16'h0000, 16'h0000, 16'hffff,
               8'h3c, 1'b1);
      ind_case(1'b0, 2'b00, 1'b0, 6'h00, 16'hffff, 16'h0000, 16'h0000,
               8'h21, 1'b0);
      ind_case(1'b1, 2'b01, 1'b0, 6'h00, 16'h0000, 16'hffff, 16'hffff,
               8'h42, 1'b1);
      ind_case(1'b0, 2'b10, 1'b1, 6'h20, 16'h0010, 16'hfff0, 16'h0010,
               8'h66, 1'b1);
      ind_case(1'b1, 2'b11, 1'b1, 6'h1f, 16'h0040, 16'h005f, 16'h0040,
               8'h77, 1'b0);
   endtask

   task automatic test_refusals();
      logic [31:0] r;
      logic e;
      wr(`REG_WREG, 32'h77);
      wr(`REG_STATUS, 32'h0);
      wr(`REG_CMD, mk_cmd(3'h6, 1'b0, 7'h01, 1'b0, 2'b00, 1'b0, 6'h00));
      rd_chk(`REG_STATUS, 32'h8);
      wr(`REG_CMD, mk_cmd(3'h7, 1'b0, 7'h01, 1'b0, 2'b00, 1'b0, 6'h00));
      rd_chk(`REG_WREG, 32'h77);
      rd_chk(`REG_STATUS, 32'h8);
      byte_case(byte_op_pkg::move_file_op, 1'b1, 7'h01, 8'h12, 8'h77,
                2'b00, 8'h12, 2'b00);
      rd_chk(`REG_CMD, mk_cmd(byte_op_pkg::move_file_op, 1'b1, 7'h01,
                              1'b0, 2'b00, 1'b0, 6'h00));
      apb(1'b0, 12'h020, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      apb(1'b1, 12'h014, 32'h5, r, e);
      chk({31'h0, e}, 32'h1);
      wr(`REG_PTR0, 32'hffffffff);
      rd_chk(`REG_PTR0, 32'h0000ffff);
   endtask

   // ==================================================
   // main sequence and watchdog
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      test_reset();
      test_increment();
      test_ior();
      test_shifts();
      test_move();
      test_indirect();
      test_refusals();
      end_of_test();
   end

   // whole run needs roughly 800 cycles; 30000 cycles, over thirty times that, is a hang
   initial begin
      #300000;
      errors++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      end_of_test();
   end
endmodule

`default_nettype wire
